// ==== rtl/pmc_pkg.sv ====
// power mode controller package: mode codes, control bit positions, timing figures
// assumes a single system clock at 25 MHz
package pmc_pkg;
   localparam int unsigned CLK_MHZ = 25;
   // power control register bit positions
   localparam int unsigned PCTL_IDLE_BIT = 0;
   localparam int unsigned PCTL_STOP_BIT = 1;
   localparam logic [7:0] PCTL_RESET = 8'h00;
   // suspend control bit position inside internal oscillator control register
   localparam int unsigned OSC_SUSP_BIT = 5;
   localparam logic [7:0] OSC_RESET = 8'h80; // oscillator enabled after reset
   localparam int unsigned OSC_EN_BIT = 7;
   // reset vector
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   // watchdog prescale
   localparam int unsigned WD_DIV = 12;
   localparam logic [3:0] WD_DIV_LAST = 4'(WD_DIV - 1);
   // missing clock detector timeout, longest time rounds down
   localparam int unsigned MCD_TIME_US = 100;
   localparam int unsigned MCD_CYCLES = MCD_TIME_US * CLK_MHZ;
   typedef enum logic [1:0] {
      PMC_RUN = 2'b00,
      PMC_IDLE = 2'b01,
      PMC_STOP = 2'b10,
      PMC_SUSPEND = 2'b11
   } pmc_mode_t;
endpackage : pmc_pkg

// ==== rtl/pmc_power_mode_controller.sv ====
// power mode controller: holds power control and oscillator control bytes, sequences
// idle, stop and suspend, runs watchdog prescaler and missing clock detector.
// assumes the cpu core gives a write strobe and an instruction-complete pulse,
// and that wake, interrupt and clock-activity inputs come from outside this clock domain.
`timescale 1ns/10ps
// Behaviour
// - three software selectable modes: idle, stop and suspend
// - idle halts cpu; clocks and peripherals keep running
// - stop halts cpu, oscillator, interrupts and timers except missing clock detector
// - suspend halts cpu and oscillator; wakes on mismatch, comparator low, timer 3 overflow
// - suspend entered by suspend bit of oscillator control register
// - writing idle bit enters idle only after writing instruction completes
// - register and memory contents kept during idle
// - idle ends on enabled interrupt or any reset
// - interrupt in idle clears idle bit and resumes cpu at next instruction
// - reset ending idle restarts fetch at address zero
// - enabled watchdog expiry gives internal reset ending idle
// - after reset watchdog enabled, clocked at system clock over twelve
// - missing clock detector resets if clock activity stalls over 100 us
module pmc_power_mode_controller #(
   parameter int unsigned MCD_LIMIT = pmc_pkg::MCD_CYCLES, // clock-stall timeout cycles
   parameter int unsigned WD_WIDTH = 16                    // watchdog counter width
) (
   input wire logic clk,                        // system clock
   input wire logic rst,                        // async reset, active high
   input wire logic pctl_wr,                    // write strobe power control reg
   input wire logic osc_wr,                     // write strobe oscillator control reg
   input wire logic [7:0] wr_data,              // write data
   input wire logic instr_done,                 // writing instruction completed
   input wire logic irq_pending,                // enabled interrupt pending (pin domain)
   input wire logic wd_disable,                 // software disables watchdog
   input wire logic wd_kick,                    // software refreshes watchdog
   input wire logic port_mismatch,              // suspend wake source (pin domain)
   input wire logic cmp_low,                    // suspend wake source (pin domain)
   input wire logic tmr3_ovf,                   // suspend wake source (pin domain)
   input wire logic clk_activity,               // oscillator activity toggle (pin domain)
   output logic [7:0] power_control_reg,        // power control byte
   output logic [7:0] internal_osc_control_reg, // oscillator control byte
   output logic cpu_halt,                       // cpu instruction sequencing halted
   output logic osc_run,                        // internal oscillator enabled
   output logic periph_clk_en,                  // interrupts and timers clocked
   output logic irq_service,                    // pulse: service interrupt on idle wake
   output logic sys_reset_req,                  // internal reset request
   output logic [15:0] fetch_addr,              // restart fetch address
   output pmc_pkg::pmc_mode_t mode              // current power mode
);
   import pmc_pkg::*;

   logic [7:0] pctl_ff;
   logic [7:0] osc_ff;
   pmc_mode_t mode_ff;
   logic [1:0] irq_s_ff, mm_s_ff, cmp_s_ff, t3_s_ff, act_s_ff;
   logic irq_sync, wake_sync, act_sync, act_prev_ff;
   logic idle_pend_ff, stop_pend_ff;
   logic [3:0] wd_pre_ff;
   logic [WD_WIDTH-1:0] wd_cnt_ff;
   logic wd_en_ff, wd_rst_ff, mcd_rst_ff, irq_svc_ff;
   logic [15:0] fetch_ff;
   logic [$clog2(MCD_LIMIT+1)-1:0] mcd_cnt_ff;

   // two-flop synchronisers; only stage 2 feeds logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_s_ff <= 2'h0;
         mm_s_ff <= 2'h0;
         cmp_s_ff <= 2'h0;
         t3_s_ff <= 2'h0;
         act_s_ff <= 2'h0;
      end else begin
         irq_s_ff <= {irq_s_ff[0], irq_pending};
         mm_s_ff <= {mm_s_ff[0], port_mismatch};
         cmp_s_ff <= {cmp_s_ff[0], cmp_low};
         t3_s_ff <= {t3_s_ff[0], tmr3_ovf};
         act_s_ff <= {act_s_ff[0], clk_activity};
      end
   end
   assign irq_sync = irq_s_ff[1];
   assign wake_sync = mm_s_ff[1] | cmp_s_ff[1] | t3_s_ff[1];
   assign act_sync = act_s_ff[1];

   // power control byte; idle/stop take effect after the instruction completes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pctl_ff <= PCTL_RESET;
         idle_pend_ff <= 1'b0;
         stop_pend_ff <= 1'b0;
      end else begin
         if (pctl_wr && mode_ff == PMC_RUN) begin
            pctl_ff <= wr_data;
            idle_pend_ff <= wr_data[PCTL_IDLE_BIT];
            stop_pend_ff <= wr_data[PCTL_STOP_BIT];
         end else if (instr_done) begin
            idle_pend_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
         end
         if (mode_ff == PMC_IDLE && irq_sync) begin
            pctl_ff[PCTL_IDLE_BIT] <= 1'b0;
         end
      end
   end

   // oscillator control byte; suspend bit cleared by hardware on wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_ff <= OSC_RESET;
      end else if (mode_ff == PMC_SUSPEND && wake_sync) begin
         osc_ff[OSC_SUSP_BIT] <= 1'b0;
         osc_ff[OSC_EN_BIT] <= 1'b1;
      end else if (osc_wr && mode_ff == PMC_RUN) begin
         osc_ff <= wr_data;
      end
   end

   // mode sequencer; stop has no exit but reset, so registers simply hold
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_ff <= PMC_RUN;
      end else begin
         case (mode_ff)
            PMC_RUN: begin
               if (instr_done && stop_pend_ff) mode_ff <= PMC_STOP;
               else if (instr_done && idle_pend_ff) mode_ff <= PMC_IDLE;
               else if (osc_ff[OSC_SUSP_BIT]) mode_ff <= PMC_SUSPEND;
            end
            PMC_IDLE: if (irq_sync) mode_ff <= PMC_RUN;
            PMC_SUSPEND: if (wake_sync) mode_ff <= PMC_RUN;
            PMC_STOP: mode_ff <= PMC_STOP;
            default: mode_ff <= PMC_RUN;
         endcase
      end
   end

   // one-cycle interrupt service pulse on idle wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) irq_svc_ff <= 1'b0;
      else irq_svc_ff <= (mode_ff == PMC_IDLE) && irq_sync;
   end

   // watchdog: enabled after any reset, ticks every twelve clocks; stopped in stop/suspend
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_en_ff <= 1'b1;
         wd_pre_ff <= 4'h0;
         wd_cnt_ff <= '0;
         wd_rst_ff <= 1'b0;
      end else begin
         wd_rst_ff <= 1'b0;
         if (wd_disable) wd_en_ff <= 1'b0;
         if (wd_kick) begin
            wd_cnt_ff <= '0;
         end else if (wd_en_ff && (mode_ff == PMC_RUN || mode_ff == PMC_IDLE)) begin
            if (wd_pre_ff == WD_DIV_LAST) begin
               wd_pre_ff <= 4'h0;
               wd_cnt_ff <= wd_cnt_ff + 1'b1;
               if (&wd_cnt_ff) wd_rst_ff <= 1'b1;
            end else begin
               wd_pre_ff <= wd_pre_ff + 4'h1;
            end
         end
      end
   end

   // missing clock detector: active in every mode; a stalled activity toggle is a dead clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_prev_ff <= 1'b0;
         mcd_cnt_ff <= '0;
         mcd_rst_ff <= 1'b0;
      end else begin
         act_prev_ff <= act_sync;
         if (act_sync != act_prev_ff) begin
            mcd_cnt_ff <= '0;
            mcd_rst_ff <= 1'b0;
         end else if (mcd_cnt_ff >= ($bits(mcd_cnt_ff))'(MCD_LIMIT)) begin
            mcd_rst_ff <= 1'b1;
         end else begin
            mcd_cnt_ff <= mcd_cnt_ff + 1'b1;
         end
      end
   end

   // restart vector after any reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) fetch_ff <= RESET_VECTOR;
      else fetch_ff <= fetch_ff;
   end

   // outputs
   assign power_control_reg = pctl_ff;
   assign internal_osc_control_reg = osc_ff;
   assign mode = mode_ff;
   assign cpu_halt = (mode_ff != PMC_RUN);
   assign osc_run = (mode_ff != PMC_STOP) && (mode_ff != PMC_SUSPEND);
   assign periph_clk_en = (mode_ff == PMC_RUN) || (mode_ff == PMC_IDLE);
   assign irq_service = irq_svc_ff;
   assign sys_reset_req = wd_rst_ff | mcd_rst_ff;
   assign fetch_addr = fetch_ff;

   property p_idle_entry;
      @(posedge clk) disable iff (rst)
      (mode_ff == PMC_RUN && instr_done && idle_pend_ff && !stop_pend_ff)
         |=> (mode_ff == PMC_IDLE && cpu_halt && periph_clk_en);
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

   property p_no_early_idle;
      @(posedge clk) disable iff (rst)
      (mode_ff == PMC_RUN && !instr_done) |=> mode_ff != PMC_IDLE;
   endproperty
   a_no_early_idle: assert property (p_no_early_idle) else $error("idle too early");

   sequence s_idle_irq;
      mode_ff == PMC_IDLE && irq_sync;
   endsequence
   property p_idle_wake;
      @(posedge clk) disable iff (rst)
      s_idle_irq |=> (mode_ff == PMC_RUN && !pctl_ff[PCTL_IDLE_BIT] && irq_service);
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");

   property p_stop_hold;
      @(posedge clk) disable iff (rst)
      mode_ff == PMC_STOP |=> (mode_ff == PMC_STOP && !osc_run && !periph_clk_en);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop exited");

   property p_susp_wake;
      @(posedge clk) disable iff (rst)
      (mode_ff == PMC_SUSPEND && wake_sync)
         |=> (mode_ff == PMC_RUN && !osc_ff[OSC_SUSP_BIT] && osc_run);
   endproperty
   a_susp_wake: assert property (p_susp_wake) else $error("suspend wake wrong");

   property p_susp_halt;
      @(posedge clk) disable iff (rst)
      mode_ff == PMC_SUSPEND |-> (cpu_halt && !osc_run);
   endproperty
   a_susp_halt: assert property (p_susp_halt) else $error("suspend not halted");

   property p_idle_halt;
      @(posedge clk) disable iff (rst)
      mode_ff == PMC_IDLE |-> (cpu_halt && osc_run && periph_clk_en);
   endproperty
   a_idle_halt: assert property (p_idle_halt) else $error("idle clocks wrong");

   property p_wd_tick;
      @(posedge clk) disable iff (rst)
      (wd_en_ff && !wd_kick && !wd_disable && mode_ff == PMC_RUN && wd_pre_ff == WD_DIV_LAST
         && !idle_pend_ff && !stop_pend_ff && !osc_ff[OSC_SUSP_BIT])
         |=> wd_pre_ff == 4'h0;
   endproperty
   a_wd_tick: assert property (p_wd_tick) else $error("watchdog prescale wrong");

   property p_mcd;
      @(posedge clk) disable iff (rst)
      (act_sync == act_prev_ff && mcd_cnt_ff >= ($bits(mcd_cnt_ff))'(MCD_LIMIT))
         |=> sys_reset_req;
   endproperty
   a_mcd: assert property (p_mcd) else $error("missing clock reset absent");
endmodule : pmc_power_mode_controller

// ==== verif/pmc_cpu_model.sv ====
// partner model: cpu completion strobe and internal oscillator activity
// assumes the bench drives pctl_wr off the falling edge, one cycle wide
`timescale 1ns/10ps
module pmc_cpu_model (
   input wire logic clk,      // system clock
   input wire logic rst,      // async reset, active high
   input wire logic pctl_wr,  // power control write seen
   input wire logic osc_run,  // oscillator enable from controller
   output logic instr_done,   // writing instruction complete
   output logic clk_activity  // oscillator alive toggle
);
   logic wr_seen_ff;
   initial begin
      instr_done = 1'b0;
      clk_activity = 1'b0;
   end
   // remember the write, close the instruction one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_seen_ff <= 1'b0;
      end else begin
         wr_seen_ff <= pctl_wr;
      end
   end
   // next instruction is multi-byte, so no interrupt race on idle entry
   always @(negedge clk) begin
      instr_done <= wr_seen_ff;
   end
   // a stopped oscillator stands still, which the clock monitor must catch
   always @(negedge clk) begin
      if (osc_run) begin
         clk_activity <= ~clk_activity;
      end
   end
endmodule : pmc_cpu_model

// ==== verif/tb_power_mode_controller.sv ====
// testbench: idle, stop, suspend, watchdog and clock monitor sequences
// assumes short counts: clock stall limit 20 cycles, watchdog width 4
`timescale 1ns/10ps
module tb_power_mode_controller;
   import pmc_pkg::*;
   localparam int MCD_LIM = 20;
   logic clk, rst, pctl_wr, osc_wr, instr_done, irq_pending, wd_disable, wd_kick;
   logic clk_activity, cpu_halt, osc_run, periph_clk_en, irq_service, sys_reset_req;
   logic [7:0] wr_data, pctl_q, osc_q, osc_d;
   logic [2:0] wake;
   logic [15:0] fetch_addr;
   pmc_mode_t mode;
   int miscompares = 0, num_checks = 0, cycles = 0, n, k, exp_mode;
   pmc_power_mode_controller #(.MCD_LIMIT(MCD_LIM), .WD_WIDTH(4)) i_dut (.clk(clk), .rst(rst),
      .pctl_wr(pctl_wr), .osc_wr(osc_wr), .wr_data(wr_data), .instr_done(instr_done),
      .irq_pending(irq_pending), .wd_disable(wd_disable), .wd_kick(wd_kick),
      .port_mismatch(wake[0]), .cmp_low(wake[1]), .tmr3_ovf(wake[2]),
      .clk_activity(clk_activity), .power_control_reg(pctl_q), .internal_osc_control_reg(osc_q),
      .cpu_halt(cpu_halt), .osc_run(osc_run), .periph_clk_en(periph_clk_en),
      .irq_service(irq_service), .sys_reset_req(sys_reset_req), .fetch_addr(fetch_addr),
      .mode(mode));
   pmc_cpu_model i_cpu (.clk(clk), .rst(rst), .pctl_wr(pctl_wr), .osc_run(osc_run),
      .instr_done(instr_done), .clk_activity(clk_activity));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   // sel low writes power control, high writes oscillator control
   task automatic wr_reg(input logic sel, input logic [7:0] d);
      @(negedge clk);
      wr_data = d;
      pctl_wr = ~sel;
      osc_wr = sel;
      @(negedge clk);
      pctl_wr = 1'b0;
      osc_wr = 1'b0;
   endtask : wr_reg
   task automatic wait_run();
      n = 0;
      while (mode !== PMC_RUN && n < 8) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_run
   task automatic wait_rst(input int lim);
      n = 0;
      while (sys_reset_req !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_rst
   task automatic do_reset();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      exp_mode = PMC_RUN;
   endtask : do_reset
   // hang guard, well above the longest sequence
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      // seventeen bits: reset high, every other input low
      {rst, pctl_wr, osc_wr, irq_pending, wd_disable, wd_kick, wake, wr_data} = 17'h10000;
      n = $urandom(32'h1564);
      repeat (20) @(negedge clk);
      rst = 1'b0;
      exp_mode = PMC_RUN;
      chk(16'(mode), 16'(exp_mode));
      chk(16'(pctl_q), 16'(PCTL_RESET));
      chk(16'(osc_q), 16'(OSC_RESET));
      chk(fetch_addr, RESET_VECTOR);
      // watchdog left enabled after reset; kick once, then idle until it bites
      repeat (100) @(negedge clk);
      wd_kick = 1'b1;
      @(negedge clk);
      wd_kick = 1'b0;
      wr_reg(1'b0, 8'h01);
      wait_rst(260);
      chk(16'(n + 3 >= 180 && n + 3 <= 210), 16'h1);
      chk(16'(mode), 16'(PMC_IDLE));
      do_reset();
      chk(16'(mode), 16'(exp_mode));
      chk(fetch_addr, RESET_VECTOR);
      wd_disable = 1'b1;
      // idle entry waits for instruction completion, interrupt wakes it
      wr_reg(1'b0, 8'h01);
      chk(16'(pctl_q), 16'h01);
      chk(16'(mode), 16'(exp_mode));
      @(negedge clk);
      exp_mode = PMC_IDLE;
      chk(16'(mode), 16'(exp_mode));
      chk(16'({cpu_halt, osc_run, periph_clk_en}), 16'h7);
      repeat ($urandom_range(3, 12)) @(negedge clk);
      chk(16'(mode), 16'(exp_mode));
      irq_pending = 1'b1;
      wait_run();
      chk(16'(n), 16'h3);
      chk(16'({irq_service, pctl_q}), 16'h100);
      chk(16'(osc_q), 16'(OSC_RESET));
      @(negedge clk);
      irq_pending = 1'b0;
      chk(16'(irq_service), 16'h0);
      // both bits: stop wins; interrupts and writes refused while stopped
      wr_reg(1'b0, 8'h03);
      @(negedge clk);
      chk(16'(mode), 16'(PMC_STOP));
      chk(16'({cpu_halt, osc_run, periph_clk_en}), 16'h4);
      irq_pending = 1'b1;
      wr_reg(1'b0, 8'h00);
      repeat (4) @(negedge clk);
      chk(16'({mode, pctl_q}), 16'h203);
      irq_pending = 1'b0;
      wait_rst(40);
      chk(16'(n + 7 >= MCD_LIM - 2 && n + 7 <= MCD_LIM + 12), 16'h1);
      @(negedge clk);
      chk(16'(sys_reset_req), 16'h1);
      do_reset();
      // suspend through oscillator control, once per wake source
      for (k = 0; k < 3; k++) begin
         // enable and suspend set, low bits random; only bit 5 steers the controller
         osc_d = {3'h5, 5'($urandom)};
         wr_reg(1'b1, osc_d);
         chk(16'(osc_q), 16'(osc_d));
         @(negedge clk);
         exp_mode = PMC_SUSPEND;
         chk(16'({mode, pctl_q}), 16'(exp_mode * 256));
         chk(16'({cpu_halt, osc_run}), 16'h2);
         repeat ($urandom_range(1, 4)) @(negedge clk);
         wake = 3'(1 << k);
         wait_run();
         chk(16'(n), 16'h3);
         chk(16'({osc_run, osc_q}), 16'h100 | 16'(osc_d & 8'hdf));
         wake = 3'h0;
         repeat (3) @(negedge clk);
      end
      test_done();
   end
endmodule : tb_power_mode_controller
